// ---- hw/uei_irq_enable.sv ----
`timescale 1ns/1ps
module uei_irq_enable
   import uei_pkg::*;
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // status flags from the event block (levels)
   input  wire logic        wakeup_seen_flag_in,
   input  wire logic        frame_start_seen_flag_in,
   input  wire logic        dev_state_change_flag_in,
   input  wire logic        ctl_stage_change_flag_in,
   input  wire logic        buffer_drained_flag_in,
   input  wire logic        ready_to_send_flag_in,
   // interrupt outputs
   output logic             irq_req_out,
   output logic             evt_irq_out
);

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic        access;
   logic        wr_en;
   logic        rd_status;
   logic        addr_ok;
   logic [15:0] enable_ff;
   logic [15:0] nxt_enable;
   logic [15:0] mask_ff;
   logic [15:0] flags;
   logic [15:0] gated;
   logic [15:0] sticky;
   logic [15:0] rise;
   logic [15:0] flags_q_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : hit

   // zero wait states: access phase completes on its first cycle
   assign access      = psel_in & penable_in;
   assign addr_ok     = hit(paddr_in, IRQ_ENABLE_OFS) | hit(paddr_in, EVT_STATUS_OFS)
                      | hit(paddr_in, EVT_MASK_OFS);
   assign wr_en       = access & pwrite_in & addr_ok;
   assign rd_status   = access & !pwrite_in & hit(paddr_in, EVT_STATUS_OFS);
   assign pready_out  = 1'b1;
   assign pslverr_out = access & !addr_ok;

   // ------------------------------------------------------------
   // interrupt-enable register
   // ------------------------------------------------------------
   always_comb begin
      nxt_enable = enable_ff;
      if (wr_en && hit(paddr_in, IRQ_ENABLE_OFS)) begin
         nxt_enable = pwdata_in[15:0] & ENABLE_MASK;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         enable_ff <= ENABLE_RESET;
      end else begin
         enable_ff <= nxt_enable;
      end
   end

   // ------------------------------------------------------------
   // gating of status flags
   // ------------------------------------------------------------
   always_comb begin
      flags                  = '0;
      flags[WAKEUP_BIT]      = wakeup_seen_flag_in;
      flags[FRAME_START_BIT] = frame_start_seen_flag_in;
      flags[DEV_STATE_BIT]   = dev_state_change_flag_in;
      flags[CTL_STAGE_BIT]   = ctl_stage_change_flag_in;
      flags[BUF_DRAIN_BIT]   = buffer_drained_flag_in;
      flags[READY_SEND_BIT]  = ready_to_send_flag_in;
   end

   // each flag passes only with its enable bit set
   assign gated       = flags & enable_ff;
   // combinational so the request follows the flags with no added latency
   assign irq_req_out = |gated;

   // ------------------------------------------------------------
   // sticky rise events, cleared by a status read
   // ------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         flags_q_ff <= EVT_RESET;
      end else begin
         flags_q_ff <= flags;
      end
   end

   assign rise = flags & ~flags_q_ff;

   uei_event_latch #(.WIDTH(ENABLE_WIDTH)) u_latch (
      .clock_in   (clock_in),
      .nrst_in    (nrst_in),
      .set_in     (rise),
      .clear_in   (rd_status),
      .sticky_out (sticky)
   );

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         mask_ff <= EVT_RESET;
      end else if (wr_en && hit(paddr_in, EVT_MASK_OFS)) begin
         mask_ff <= pwdata_in[15:0] & ENABLE_MASK;
      end
   end

   assign evt_irq_out = |(sticky & mask_ff);

   // ------------------------------------------------------------
   // read data, registered in the setup cycle
   // ------------------------------------------------------------
   always_comb begin
      nxt_prdata = ERR_DATA;
      if (hit(paddr_in, IRQ_ENABLE_OFS)) begin
         nxt_prdata = {16'h0000, enable_ff};
      end else if (hit(paddr_in, EVT_STATUS_OFS)) begin
         // a rise latched at the setup edge is reported now, as the access edge clears it
         nxt_prdata = {16'h0000, sticky | rise};
      end else if (hit(paddr_in, EVT_MASK_OFS)) begin
         nxt_prdata = {16'h0000, mask_ff};
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         prdata_ff <= ERR_DATA;
      end else if (psel_in && !penable_in) begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata_out = prdata_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   frame_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (frame_start_seen_flag_in && enable_ff[FRAME_START_BIT]) |-> irq_req_out)
      else $error("frame start flag enabled but no request");
   dev_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (dev_state_change_flag_in && enable_ff[DEV_STATE_BIT]) |-> irq_req_out)
      else $error("device state flag enabled but no request");
   ctl_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (ctl_stage_change_flag_in && enable_ff[CTL_STAGE_BIT]) |-> irq_req_out)
      else $error("control stage flag enabled but no request");
   buf_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (buffer_drained_flag_in && enable_ff[BUF_DRAIN_BIT]) |-> irq_req_out)
      else $error("buffer drained flag enabled but no request");
   wake_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (wakeup_seen_flag_in && enable_ff[WAKEUP_BIT]) |-> irq_req_out)
      else $error("wakeup flag enabled but no request");
   wake_reset_a: assert property (@(posedge clock_in)
      $rose(nrst_in) |-> !enable_ff[WAKEUP_BIT])
      else $error("wakeup enable not zero after reset");
   irq_quiet_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      irq_req_out |-> ((wakeup_seen_flag_in && enable_ff[WAKEUP_BIT])
         || (frame_start_seen_flag_in && enable_ff[FRAME_START_BIT])
         || (dev_state_change_flag_in && enable_ff[DEV_STATE_BIT])
         || (ctl_stage_change_flag_in && enable_ff[CTL_STAGE_BIT])
         || (buffer_drained_flag_in && enable_ff[BUF_DRAIN_BIT])
         || (ready_to_send_flag_in && enable_ff[READY_SEND_BIT])))
      else $error("request with no enabled flag");
   enable_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (wr_en && hit(paddr_in, IRQ_ENABLE_OFS)) |=> (enable_ff == $past(pwdata_in[15:0] & ENABLE_MASK)))
      else $error("enable write not stored");
   irq_idle_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (enable_ff == 16'h0000) |-> !irq_req_out)
      else $error("request with all enables clear");
   enable_bits_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (enable_ff & ~ENABLE_MASK) == 16'h0000)
      else $error("enable bit set outside the implemented field");
   wr_ignore_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (access && pwrite_in && !addr_ok) |=> (enable_ff == $past(enable_ff)))
      else $error("unmapped write changed the enable register");
   err_mapped_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (access && addr_ok) |-> !pslverr_out)
      else $error("error response on a mapped register");
   enable_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (psel_in && !penable_in && hit(paddr_in, IRQ_ENABLE_OFS))
      |=> (prdata_out == {16'h0000, $past(enable_ff)}))
      else $error("enable read data wrong");
   mask_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (wr_en && hit(paddr_in, EVT_MASK_OFS))
      |=> (mask_ff == $past(pwdata_in[15:0] & ENABLE_MASK)))
      else $error("mask write not stored");

   // ------------------------------------------------------------
   // sticky status checks
   // ------------------------------------------------------------
   status_set_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (|rise) |=> ((sticky & $past(rise)) == $past(rise)))
      else $error("rising flag not caught in status");
   status_clear_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (rd_status && !(|rise)) |=> (sticky == 16'h0000))
      else $error("status read did not clear");
   status_keep_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !rd_status |=> ((sticky & $past(sticky)) == $past(sticky)))
      else $error("status bit lost without a read");

endmodule : uei_irq_enable

// ---- hw/uei_pkg.sv ----
package uei_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h00;
   localparam logic [7:0] EVT_STATUS_OFS = 8'h04;
   localparam logic [7:0] EVT_MASK_OFS   = 8'h08;

   // ------------------------------------------------------------
   // enable register field positions
   // ------------------------------------------------------------
   localparam int WAKEUP_BIT      = 14;
   localparam int FRAME_START_BIT = 13;
   localparam int DEV_STATE_BIT   = 12;
   localparam int CTL_STAGE_BIT   = 11;
   localparam int BUF_DRAIN_BIT   = 10;
   localparam int READY_SEND_BIT  = 9;

   localparam int               ENABLE_WIDTH = 16;
   localparam logic [15:0]      ENABLE_RESET = 16'h0000;
   localparam logic [15:0]      ENABLE_MASK  = 16'h7e00;
   localparam logic [15:0]      EVT_RESET    = 16'h0000;
   localparam logic [31:0]      ERR_DATA     = 32'h0000_0000;

endpackage : uei_pkg

// ---- hw/uei_event_latch.sv ----
`timescale 1ns/1ps
// sticky event bits: set wins over a read-clear in the same cycle
module uei_event_latch
   import uei_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clock_in,
   input  wire logic             nrst_in,
   // events
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear_in,
   // state
   output logic      [WIDTH-1:0] sticky_out
);

   logic [WIDTH-1:0] sticky_ff;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         sticky_ff <= '0;
      end else if (clear_in) begin
         sticky_ff <= set_in;
      end else begin
         sticky_ff <= sticky_ff | set_in;
      end
   end

   assign sticky_out = sticky_ff;

endmodule : uei_event_latch

// ---- sim/uei_flag_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// status block stand-in: flags are levels held until dropped
// ------------------------------------------------------------
module uei_flag_model (
   input  wire logic       clock_in,
   input  wire logic       nrst_in,
   input  wire logic [5:0] cmd_in,
   output logic      [5:0] flags_out
);
   logic [5:0] flags_ff;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         flags_ff <= 6'h00;
      end else begin
         flags_ff <= cmd_in;
      end
   end

   assign flags_out = flags_ff;
endmodule : uei_flag_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
   import uei_pkg::*;
   logic        clock_in = 1'b0;
   logic        nrst_in  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [5:0]  flag_cmd = 6'h00;
   logic [31:0] prdata, rd;
   logic [5:0]  flags;
   logic        pready, pslverr, irq, evt_irq, err;
   int          n_fail = 0;
   int          samples_checked = 0;

   always #12.5 clock_in = ~clock_in;

   uei_flag_model flag_src (.clock_in(clock_in), .nrst_in(nrst_in), .cmd_in(flag_cmd),
                            .flags_out(flags));

   uei_irq_enable dut (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .ready_to_send_flag_in(flags[0]), .buffer_drained_flag_in(flags[1]),
      .ctl_stage_change_flag_in(flags[2]), .dev_state_change_flag_in(flags[3]),
      .frame_start_seen_flag_in(flags[4]), .wakeup_seen_flag_in(flags[5]),
      .irq_req_out(irq), .evt_irq_out(evt_irq));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // the request is held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      while (pready !== 1'b1) @(posedge clock_in);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one edge to launch the command, one for the model to register it
   task automatic set_flags(input logic [5:0] v);
      @(posedge clock_in);
      flag_cmd <= v;
      @(posedge clock_in);
      #1;
   endtask : set_flags

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20) @(posedge clock_in);
      nrst_in <= 1'b1;
      apb(1'b0, IRQ_ENABLE_OFS, 32'h0);
      check("enable reset", rd, {16'h0, ENABLE_RESET});
      check("irq after reset", irq, 1'b0);
      check("mapped err", err, 1'b0);
      apb(1'b1, IRQ_ENABLE_OFS, 32'hffff_ffff);
      apb(1'b0, IRQ_ENABLE_OFS, 32'h0);
      check("enable readback", rd, {16'h0, ENABLE_MASK});
      // each enable alone: only its own flag may raise the request
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, IRQ_ENABLE_OFS, 32'h1 << (READY_SEND_BIT + i));
         set_flags(~(6'h01 << i));
         check("irq other flags", irq, 1'b0);
         set_flags(6'h01 << i);
         check("irq own flag", irq, 1'b1);
         set_flags(6'h00);
         check("irq flag dropped", irq, 1'b0);
      end
      apb(1'b1, IRQ_ENABLE_OFS, 32'h0000_7c00);
      set_flags(6'h0c);
      check("irq two flags", irq, 1'b1);
      set_flags(6'h08);
      check("irq one left", irq, 1'b1);
      set_flags(6'h00);
      check("irq all cleared", irq, 1'b0);
      apb(1'b1, EVT_MASK_OFS, 32'h0000_7e00);
      apb(1'b0, EVT_STATUS_OFS, 32'h0);
      set_flags(6'h10);
      // the rise is latched one edge after the flag level appears
      @(posedge clock_in);
      #1;
      check("event irq", evt_irq, 1'b1);
      apb(1'b0, EVT_STATUS_OFS, 32'h0);
      check("status", rd, 32'h0000_2000);
      apb(1'b0, EVT_STATUS_OFS, 32'h0);
      check("status cleared", rd, 32'h0);
      check("event irq cleared", evt_irq, 1'b0);
      apb(1'b1, 8'h20, 32'hffff_ffff);
      check("unmapped write err", err, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped read", rd, ERR_DATA);
      check("unmapped read err", err, 1'b1);
      apb(1'b0, IRQ_ENABLE_OFS, 32'h0);
      check("enable untouched", rd, 32'h0000_7c00);
      // a mid-run reset must clear the enables; the frame flag is reset with the model and is up again one edge after release
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      apb(1'b0, IRQ_ENABLE_OFS, 32'h0);
      check("enable after mid reset", rd, {16'h0, ENABLE_RESET});
      check("irq after mid reset", irq, 1'b0);
      report_and_stop();
   end

   initial begin
      repeat (3000) @(posedge clock_in);
      n_fail++;
      report_and_stop();
   end
endmodule : tb
